// File: rtl/msg_glue.sv
// Notes on behaviour
// RQ1: Oscillator clock divided, driven to controller clock
// RQ2: Controller shares low address and data on port
// RQ3: Low address byte latched onto SRAM lines
// RQ4: Controller drives upper address byte directly
// RQ5: Small SRAM uses seven upper bits only
// RQ6: Decode upper address and strobes to selects
// RQ7: High select fully disables SRAM, high enable only turns off its output
// RQ8: Glue output drives controller reset, high isolates
// RQ9: Controller pins pulled high during its reset, address latch strobe held low
// RQ10: Glue pin tristated when external circuit drives
// RQ11: Glue may raise controller interrupt requests
// RQ12: Display driven from port or mapped latch
// RQ13: Host parallel data forwarded to controller port
// RQ14: Status lines driven by one party only
// RQ15: Controller write strobe doubles as SRAM write
// RQ16: Latch follows strobe high, holds after fall
// RQ17: Output enable only on fetch or read
`timescale 1ns/100ps
module msg_glue
  import msg_pkg::*;
#(
  parameter bit LARGE_SRAM = 1'b0,
  parameter int RESET_CYCLES = CONTROLLER_RESET_CYCLES,
  parameter int HALF_PERIOD = CLOCK_HALF_PERIOD_CYCLES
)
(
  input wire logic clock,
  input wire logic nrst,
  msg_link_if.glue_end link,
  input wire logic hold_controller,
  input wire logic [DATA_W-1:0] pc_data,
  input wire logic forward_pc_data,
  input wire logic [DATA_W-1:0] external_drives_port_a,
  input wire logic irq_assert,
  input wire logic external_drives_irq,
  input wire logic status_to_controller,
  input wire logic [STATUS_W-1:0] glue_status_data,
  input wire logic segments_from_port,
  output logic [DATA_W-1:0] sram_addr_low,
  output logic [DATA_W-1:0] sram_addr_high,
  output logic sram_chip_select_n,
  output logic sram_output_enable_n,
  output logic sram_write_enable_n,
  output logic [SEG_W-1:0] segments
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [DATA_W-1:0] mask_high(input logic [DATA_W-1:0] a);
    logic [DATA_W-1:0] m;
    m = LARGE_SRAM ? PULLED_HIGH : (PULLED_HIGH >> (LARGE_HIGH_BITS - SMALL_HIGH_BITS));
    return a & m;
  endfunction

  localparam int RCW = $clog2(RESET_CYCLES + 1);
  localparam int DCW = $clog2(HALF_PERIOD + 1);
  localparam logic [RCW-1:0] RESET_LAST = RCW'(RESET_CYCLES - 1);
  localparam logic [DCW-1:0] DIV_LAST = DCW'(HALF_PERIOD - 1);

  logic [DCW-1:0] div_count;
  logic [RCW-1:0] reset_count;
  logic reset_stretch;
  logic controller_clock;
  logic controller_reset;
  logic [DATA_W-1:0] seg_capture;
  logic [SEG_W-1:0] seg_latch;
  logic write_seen;
  logic [DATA_W-1:0] port_a_out;
  logic [DATA_W-1:0] port_a_oe_n;
  logic irq_out;
  logic irq_oe_n;
  logic grant_mcu;
  logic [STATUS_W-1:0] status_out;

  // ************************************************************
  // Decode
  // ************************************************************
  wire fetch = !link.program_fetch_strobe_n;
  wire data_read = !link.read_strobe_n;
  wire data_write = !link.write_strobe_pin_n;
  wire seg_page = (link.high_address_port == SEG_LATCH_PAGE);
  wire access = fetch | data_read | data_write;
  // RQ6: select from address and strobes
  wire sram_hit = access & !(seg_page & (data_write | data_read));
  // RQ7: reset holds both selects high
  wire next_cs_n = !(sram_hit & !controller_reset);
  // RQ17: enable only on fetch or read
  wire next_oe_n = !((fetch | data_read) & !data_write & sram_hit & !controller_reset);
  // RQ15: write strobe reaches SRAM enable
  wire next_we_n = link.write_strobe_pin_n | controller_reset;
  wire seg_write_end = write_seen & !data_write;
  wire [DATA_W-1:0] next_port_a_out = forward_pc_data ? pc_data : PULLED_HIGH;
  // RQ10: release lines the outside drives
  wire [DATA_W-1:0] next_port_a_oe_n = ~({DATA_W{forward_pc_data}} & ~external_drives_port_a);
  wire [SEG_W-1:0] next_segments = segments_from_port ? link.general_io_port_a[SEG_W-1:0] :
                                   seg_latch;

  // ************************************************************
  // Controller clock and reset
  // ************************************************************
  // RQ1: divide oscillator for controller clock
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      div_count <= '0;
      controller_clock <= 1'b0;
    end
    else if (div_count == DIV_LAST)
    begin
      div_count <= '0;
      controller_clock <= !controller_clock;
    end
    else
      div_count <= div_count + 1'b1;
  end

  // Stretch keeps the controller quiet until the clock has run a while
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      reset_count <= '0;
      reset_stretch <= 1'b1;
    end
    else if (reset_count == RESET_LAST)
      reset_stretch <= 1'b0;
    else
      reset_count <= reset_count + 1'b1;
  end

  // RQ8: drive controller reset, high isolates it
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      controller_reset <= 1'b1;
    else
      controller_reset <= reset_stretch | hold_controller;
  end

  // ************************************************************
  // SRAM address and selects
  // ************************************************************
  // RQ16: transparent while strobe high, hold after
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      sram_addr_low <= ADDR_ZERO;
    // RQ3: capture low byte from shared port
    else if (link.address_latch_strobe)
      sram_addr_low <= link.mux_addr_data_port;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sram_addr_high <= ADDR_ZERO;
      sram_chip_select_n <= 1'b1;
      sram_output_enable_n <= 1'b1;
      sram_write_enable_n <= 1'b1;
    end
    else
    begin
      // RQ5: small part drops the top bit
      sram_addr_high <= mask_high(link.high_address_port);
      sram_chip_select_n <= next_cs_n;
      sram_output_enable_n <= next_oe_n;
      sram_write_enable_n <= next_we_n;
    end
  end

  // ************************************************************
  // Display latch
  // ************************************************************
  // Data is sampled on each low cycle and kept on the strobe's rise
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      write_seen <= 1'b0;
      seg_capture <= ADDR_ZERO;
      seg_latch <= SEG_OFF;
    end
    else
    begin
      write_seen <= data_write & seg_page;
      if (data_write & seg_page)
        seg_capture <= link.mux_addr_data_port;
      // RQ12: mapped latch written by the controller
      if (seg_write_end)
        seg_latch <= seg_capture[SEG_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      segments <= SEG_OFF;
    else
      segments <= next_segments;
  end

  // ************************************************************
  // Port, interrupt and status drivers
  // ************************************************************
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      port_a_out <= PULLED_HIGH;
      port_a_oe_n <= PULLED_HIGH;
      irq_out <= 1'b1;
      irq_oe_n <= 1'b1;
      grant_mcu <= 1'b1;
      status_out <= STATUS_IDLE;
    end
    else
    begin
      // RQ13: forward host data to port
      port_a_out <= next_port_a_out;
      port_a_oe_n <= next_port_a_oe_n;
      // RQ11: drive interrupt request low
      irq_out <= !irq_assert;
      // RQ10: float when outside drives interrupt
      irq_oe_n <= !irq_assert | external_drives_irq;
      // RQ14: one owner of the status lines
      grant_mcu <= status_to_controller;
      status_out <= status_to_controller ? STATUS_IDLE : glue_status_data;
    end
  end

  assign link.controller_clock_input = controller_clock;
  assign link.controller_reset = controller_reset;
  assign link.port_a_glue_out = port_a_out;
  assign link.port_a_glue_oe_n = port_a_oe_n;
  assign link.irq_glue_out = irq_out;
  assign link.irq_glue_oe_n = irq_oe_n;
  assign link.status_grant_mcu = grant_mcu;
  assign link.status_glue_out = status_out;

endmodule // msg_glue

// File: rtl/msg_pkg.sv
package msg_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int SEG_W = 7;
  localparam int STATUS_W = 4;
  localparam int SMALL_HIGH_BITS = 7;
  localparam int LARGE_HIGH_BITS = 8;

  // ************************************************************
  // Reset values and fixed codes
  // ************************************************************
  localparam logic [DATA_W-1:0] PULLED_HIGH = 8'hFF;
  localparam logic [DATA_W-1:0] ADDR_ZERO = 8'h00;
  localparam logic [SEG_W-1:0] SEG_OFF = 7'h00;
  localparam logic [STATUS_W-1:0] STATUS_IDLE = 4'hF;
  localparam logic [DATA_W-1:0] SEG_LATCH_PAGE = 8'hFF;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int CONTROLLER_RESET_NS = 1000;
  localparam int CONTROLLER_RESET_CYCLES =
    (CONTROLLER_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CLOCK_HALF_PERIOD_CYCLES = 2;

  // ************************************************************
  // Bus cycle kinds and controller-end states
  // ************************************************************
  typedef enum logic [1:0]
  {
    MSG_FETCH = 2'h0,
    MSG_READ = 2'h1,
    MSG_WRITE = 2'h2
  } msg_kind_type;

  typedef enum logic [2:0]
  {
    MSG_IDLE = 3'h0,
    MSG_LATCH = 3'h1,
    MSG_HOLD = 3'h3,
    MSG_STROBE = 3'h2,
    MSG_FINISH = 3'h6
  } msg_state_type;

endpackage

// File: rtl/msg_link_if.sv
`timescale 1ns/100ps
interface msg_link_if;
  import msg_pkg::*;

  logic controller_clock_input;
  logic controller_reset;
  logic [DATA_W-1:0] mux_mcu_out;
  logic mux_mcu_oe_n;
  logic [DATA_W-1:0] mux_ext_data;
  logic mux_ext_oe_n;
  logic [DATA_W-1:0] mux_addr_data_port;
  logic [DATA_W-1:0] high_address_port;
  logic address_latch_strobe;
  logic program_fetch_strobe_n;
  logic write_strobe_pin_n;
  logic read_strobe_n;
  logic [DATA_W-1:0] port_a_mcu_out;
  logic [DATA_W-1:0] port_a_mcu_oe_n;
  logic [DATA_W-1:0] port_a_glue_out;
  logic [DATA_W-1:0] port_a_glue_oe_n;
  logic [DATA_W-1:0] general_io_port_a;
  logic irq_glue_out;
  logic irq_glue_oe_n;
  logic irq_ext_out;
  logic irq_ext_oe_n;
  logic irq_request_n_level;
  logic status_grant_mcu;
  logic [STATUS_W-1:0] status_glue_out;
  logic [STATUS_W-1:0] status_mcu_out;
  logic status_mcu_oe_n;
  logic [STATUS_W-1:0] status_level;

  // ************************************************************
  // Wire levels
  // ************************************************************
  // Undriven nets rest at the weak pull-up level
  assign mux_addr_data_port = !mux_mcu_oe_n ? mux_mcu_out :
                              (!mux_ext_oe_n ? mux_ext_data : PULLED_HIGH);
  assign general_io_port_a = (port_a_mcu_oe_n | port_a_mcu_out) &
                             (port_a_glue_oe_n | port_a_glue_out);
  assign irq_request_n_level = (irq_glue_oe_n | irq_glue_out) &
                               (irq_ext_oe_n | irq_ext_out);
  assign status_level = !status_grant_mcu ? status_glue_out :
                        (status_mcu_oe_n ? STATUS_IDLE : status_mcu_out);

  modport glue_end
  (
    output controller_clock_input,
    output controller_reset,
    output port_a_glue_out,
    output port_a_glue_oe_n,
    output irq_glue_out,
    output irq_glue_oe_n,
    output status_grant_mcu,
    output status_glue_out,
    input mux_addr_data_port,
    input high_address_port,
    input address_latch_strobe,
    input program_fetch_strobe_n,
    input write_strobe_pin_n,
    input read_strobe_n,
    input general_io_port_a
  );

  modport mcu_end
  (
    input controller_clock_input,
    input controller_reset,
    input mux_addr_data_port,
    input general_io_port_a,
    input irq_request_n_level,
    input status_grant_mcu,
    output mux_mcu_out,
    output mux_mcu_oe_n,
    output high_address_port,
    output address_latch_strobe,
    output program_fetch_strobe_n,
    output write_strobe_pin_n,
    output read_strobe_n,
    output port_a_mcu_out,
    output port_a_mcu_oe_n,
    output status_mcu_out,
    output status_mcu_oe_n
  );

endinterface

// File: rtl/msg_mcu.sv
`timescale 1ns/100ps
module msg_mcu
  import msg_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  msg_link_if.mcu_end link,
  input wire logic req_valid,
  input wire msg_kind_type req_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [DATA_W-1:0] port_a_value,
  input wire logic [STATUS_W-1:0] status_value,
  output logic req_ready,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic irq_seen
);

  msg_state_type state;
  msg_kind_type kind;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] mux_out;
  logic mux_oe_n;
  logic [DATA_W-1:0] high_out;
  logic ale;
  logic psen_n;
  logic wr_n;
  logic rd_n;
  logic [DATA_W-1:0] pa_oe_n;
  logic st_oe_n;

  // ************************************************************
  // Cycle sequencing
  // ************************************************************
  // RQ9: pins released while held in reset
  wire held = link.controller_reset;
  wire start = (state == MSG_IDLE) & req_valid & !held;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= MSG_IDLE;
      kind <= MSG_FETCH;
      addr <= '0;
      wdata <= ADDR_ZERO;
      done <= 1'b0;
      rdata <= ADDR_ZERO;
    end
    else
    begin
      done <= 1'b0;
      unique case (state)
        MSG_IDLE:
          if (start)
          begin
            kind <= req_kind;
            addr <= req_addr;
            wdata <= req_wdata;
            state <= MSG_LATCH;
          end
        MSG_LATCH:
          state <= MSG_HOLD;
        MSG_HOLD:
          state <= MSG_STROBE;
        MSG_STROBE:
          state <= MSG_FINISH;
        // Glue selects lag the strobe a cycle, so read data stands only now
        MSG_FINISH:
        begin
          if (kind != MSG_WRITE)
            rdata <= link.mux_addr_data_port;
          done <= 1'b1;
          state <= MSG_IDLE;
        end
        default:
          state <= MSG_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  // Strobe spans two cycles to cover the registered selects
  wire in_strobe = (state == MSG_HOLD) | (state == MSG_STROBE);
  wire addr_phase = (state == MSG_LATCH) | (state == MSG_HOLD);
  wire write_phase = in_strobe & (kind == MSG_WRITE);
  // RQ2: low address then data on shared port
  wire [DATA_W-1:0] next_mux = write_phase ? wdata : addr[DATA_W-1:0];
  wire next_mux_oe_n = held | !(addr_phase | write_phase);
  wire next_ale = (state == MSG_LATCH) & !held;
  // RQ4: upper byte on its own port
  wire [DATA_W-1:0] next_high = held ? PULLED_HIGH : addr[ADDR_W-1:DATA_W];

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      mux_out <= PULLED_HIGH;
      mux_oe_n <= 1'b1;
      high_out <= PULLED_HIGH;
      ale <= 1'b0;
      psen_n <= 1'b1;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      pa_oe_n <= PULLED_HIGH;
      st_oe_n <= 1'b1;
      req_ready <= 1'b0;
      irq_seen <= 1'b0;
    end
    else
    begin
      mux_out <= next_mux;
      mux_oe_n <= next_mux_oe_n;
      high_out <= next_high;
      ale <= next_ale;
      psen_n <= !(in_strobe & (kind == MSG_FETCH)) | held;
      // RQ15: one strobe writes the SRAM
      wr_n <= !write_phase | held;
      rd_n <= !(in_strobe & (kind == MSG_READ)) | held;
      pa_oe_n <= held ? PULLED_HIGH : port_a_value;
      // RQ14: drive status only when granted
      st_oe_n <= held | !link.status_grant_mcu;
      req_ready <= (state == MSG_IDLE) & !start & !held;
      irq_seen <= !link.irq_request_n_level;
    end
  end

  assign link.mux_mcu_out = mux_out;
  assign link.mux_mcu_oe_n = mux_oe_n;
  assign link.high_address_port = high_out;
  assign link.address_latch_strobe = ale;
  assign link.program_fetch_strobe_n = psen_n;
  assign link.write_strobe_pin_n = wr_n;
  assign link.read_strobe_n = rd_n;
  assign link.port_a_mcu_out = ADDR_ZERO;
  assign link.port_a_mcu_oe_n = pa_oe_n;
  assign link.status_mcu_out = status_value;
  assign link.status_mcu_oe_n = st_oe_n;

endmodule // msg_mcu

// File: tb/msg_link_properties.sv
`timescale 1ns/100ps
module msg_link_properties
  import msg_pkg::*;
#(
  parameter bit LARGE_SRAM = 1'b0,
  parameter int HALF_PERIOD = CLOCK_HALF_PERIOD_CYCLES
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic controller_clock_input,
  input wire logic controller_reset,
  input wire logic [DATA_W-1:0] mux_addr_data_port,
  input wire logic [DATA_W-1:0] high_address_port,
  input wire logic address_latch_strobe,
  input wire logic program_fetch_strobe_n,
  input wire logic write_strobe_pin_n,
  input wire logic read_strobe_n,
  input wire logic mux_mcu_oe_n,
  input wire logic [DATA_W-1:0] sram_addr_low,
  input wire logic [DATA_W-1:0] sram_addr_high,
  input wire logic sram_chip_select_n,
  input wire logic sram_output_enable_n
);
  // ************************************************************
  // Link checks
  // ************************************************************
  localparam logic [DATA_W-1:0] HIGH_MASK = LARGE_SRAM ? 8'hFF : 8'h7F;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_clock_half;
    $rose(controller_clock_input) |-> ##HALF_PERIOD $fell(controller_clock_input);
  endproperty
  a_clock_half: assert property (p_clock_half)
    else $error("controller clock half period wrong");

  property p_latch_capture;
    address_latch_strobe |=> sram_addr_low == $past(mux_addr_data_port);
  endproperty
  a_latch_capture: assert property (p_latch_capture)
    else $error("low address not captured");

  property p_latch_hold;
    !address_latch_strobe |=> $stable(sram_addr_low);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("low address changed without strobe");

  property p_high_mask;
    $past(nrst) |-> sram_addr_high == ($past(high_address_port) & HIGH_MASK);
  endproperty
  a_high_mask: assert property (p_high_mask)
    else $error("upper address bits wrong");

  property p_fetch_select;
    !program_fetch_strobe_n && !controller_reset |=>
      !sram_chip_select_n && !sram_output_enable_n;
  endproperty
  a_fetch_select: assert property (p_fetch_select)
    else $error("fetch did not enable memory");

  property p_write_no_oe;
    !write_strobe_pin_n |=> sram_output_enable_n;
  endproperty
  a_write_no_oe: assert property (p_write_no_oe)
    else $error("output enable low during write");

  property p_idle_deselect;
    read_strobe_n && write_strobe_pin_n && program_fetch_strobe_n |=>
      sram_chip_select_n && sram_output_enable_n;
  endproperty
  a_idle_deselect: assert property (p_idle_deselect)
    else $error("memory enabled with no strobe");

  property p_reset_isolate;
    controller_reset [*2] |-> sram_chip_select_n && sram_output_enable_n;
  endproperty
  a_reset_isolate: assert property (p_reset_isolate)
    else $error("memory enabled during controller reset");

  property p_reset_pins;
    controller_reset [*2] |-> !address_latch_strobe && mux_mcu_oe_n && read_strobe_n
      && write_strobe_pin_n && program_fetch_strobe_n;
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("controller pins active during reset");
endmodule // msg_link_properties

// File: tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
`define WAIT(c) \
  begin \
    n = 0; \
    while (!(c) && n < 60) \
    begin \
      @(negedge clock); \
      n++; \
    end \
    if (!(c)) \
    begin \
      err_count++; \
      test_done(); \
    end \
  end
module tb_top;
  import msg_pkg::*;
  logic clock = 1'b0;
  logic nrst, hold_controller, forward_pc_data, irq_assert, external_drives_irq;
  logic status_to_controller, segments_from_port, req_valid;
  logic [7:0] pc_data, external_drives_port_a, req_wdata, port_a_value, rdata, wbuf;
  logic [3:0] glue_status_data, status_value;
  logic [15:0] req_addr;
  msg_kind_type req_kind;
  logic [7:0] sram_addr_low, sram_addr_high;
  logic sram_chip_select_n, sram_output_enable_n, sram_write_enable_n;
  logic req_ready, done, irq_seen;
  logic [6:0] segments, seg_exp;
  logic [7:0] sram_mem [0:32767];
  logic [7:0] ref_mem [int];
  logic [7:0] pages [4] = '{8'h01, 8'h81, 8'hFF, 8'h7F};
  int err_count = 0;
  int comparisons = 0;
  int seed = 14;
  int r, i, n;

  msg_link_if link();
  msg_glue #(.LARGE_SRAM(1'b0), .RESET_CYCLES(4)) u_msg_glue (.clock(clock), .nrst(nrst),
    .link(link), .hold_controller(hold_controller), .pc_data(pc_data),
    .forward_pc_data(forward_pc_data), .external_drives_port_a(external_drives_port_a),
    .irq_assert(irq_assert), .external_drives_irq(external_drives_irq),
    .status_to_controller(status_to_controller), .glue_status_data(glue_status_data),
    .segments_from_port(segments_from_port), .sram_addr_low(sram_addr_low),
    .sram_addr_high(sram_addr_high), .sram_chip_select_n(sram_chip_select_n),
    .sram_output_enable_n(sram_output_enable_n),
    .sram_write_enable_n(sram_write_enable_n), .segments(segments));
  msg_mcu u_msg_mcu (.clock(clock), .nrst(nrst), .link(link), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata),
    .port_a_value(port_a_value), .status_value(status_value), .req_ready(req_ready),
    .done(done), .rdata(rdata), .irq_seen(irq_seen));
  msg_link_properties #(.LARGE_SRAM(1'b0)) u_msg_link_properties (.clock(clock),
    .nrst(nrst), .controller_clock_input(link.controller_clock_input),
    .controller_reset(link.controller_reset), .mux_addr_data_port(link.mux_addr_data_port),
    .high_address_port(link.high_address_port),
    .address_latch_strobe(link.address_latch_strobe),
    .program_fetch_strobe_n(link.program_fetch_strobe_n),
    .write_strobe_pin_n(link.write_strobe_pin_n), .read_strobe_n(link.read_strobe_n),
    .mux_mcu_oe_n(link.mux_mcu_oe_n), .sram_addr_low(sram_addr_low),
    .sram_addr_high(sram_addr_high), .sram_chip_select_n(sram_chip_select_n),
    .sram_output_enable_n(sram_output_enable_n));

  always #5 clock = ~clock;

  // ************************************************************
  // Memory beside the link
  // ************************************************************
  // Write data is taken while the controller strobe is low, because the
  // registered write enable lags the strobe a cycle and ends a cycle after the controller lets go
  assign link.mux_ext_oe_n = sram_chip_select_n | sram_output_enable_n;
  assign link.mux_ext_data = sram_mem[{sram_addr_high[6:0], sram_addr_low}];
  always @(posedge clock)
  begin
    if (!link.write_strobe_pin_n)
      wbuf <= link.mux_addr_data_port;
    if (!sram_chip_select_n && !sram_write_enable_n)
      sram_mem[{sram_addr_high[6:0], sram_addr_low}] <= wbuf;
  end

  function automatic logic [7:0] init_byte(input int a);
    return a[7:0] ^ a[14:7];
  endfunction

  task test_done;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic run_op(input msg_kind_type k, input logic [15:0] a, input logic [7:0] d);
    int m;
    logic [7:0] exp;
    m = a & 16'h7FFF;
    `WAIT(req_ready === 1'b1)
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    `WAIT(done === 1'b1)
    `CHK({sram_addr_high, sram_addr_low}, {1'b0, a[14:0]})
    if (k == MSG_WRITE && a[15:8] == 8'hFF)
    begin
      seg_exp = d[6:0];
      repeat (3) @(negedge clock);
      `CHK(segments, seg_exp)
    end
    else if (k == MSG_WRITE)
      ref_mem[m] = d;
    else
    begin
      exp = ref_mem.exists(m) ? ref_mem[m] : init_byte(m);
      if (k == MSG_READ && a[15:8] == 8'hFF)
        exp = 8'hFF;
      `CHK(rdata, exp)
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    nrst = 1'b0;
    {hold_controller, forward_pc_data, irq_assert, external_drives_irq} = 4'h0;
    {status_to_controller, segments_from_port, req_valid} = 3'h0;
    {pc_data, external_drives_port_a, req_wdata, req_addr} = 40'h0;
    port_a_value = 8'hFF;
    {glue_status_data, status_value} = 8'h00;
    req_kind = MSG_FETCH;
    {link.irq_ext_out, link.irq_ext_oe_n} = 2'h3;
    for (i = 0; i < 32768; i++)
      sram_mem[i] = init_byte(i);
    repeat (5) @(negedge clock);
    `CHK({link.controller_reset, sram_chip_select_n, sram_output_enable_n}, 3'h7)
    nrst = 1'b1;
    `WAIT(link.controller_reset === 1'b0)
    for (i = 0; i < 40; i++)
    begin
      r = $random(seed);
      run_op(msg_kind_type'(r[1:0] == 2'h3 ? 2'h1 : r[1:0]),
        {pages[r[9:8]], 4'h0, r[7:4]}, r[23:16]);
    end
    r = $random(seed);
    pc_data = r[7:0];
    forward_pc_data = 1'b1;
    repeat (2) @(negedge clock);
    `CHK(link.general_io_port_a, pc_data)
    segments_from_port = 1'b1;
    repeat (3) @(negedge clock);
    `CHK(segments, pc_data[6:0])
    external_drives_port_a = 8'hF0;
    repeat (2) @(negedge clock);
    `CHK(link.general_io_port_a, pc_data | 8'hF0)
    port_a_value = r[23:16];
    repeat (2) @(negedge clock);
    `CHK(link.general_io_port_a, (pc_data | 8'hF0) & port_a_value)
    irq_assert = 1'b1;
    `WAIT(irq_seen === 1'b1)
    `CHK(link.irq_request_n_level, 1'b0)
    external_drives_irq = 1'b1;
    `WAIT(irq_seen === 1'b0)
    `CHK(link.irq_request_n_level, 1'b1)
    glue_status_data = r[11:8];
    repeat (2) @(negedge clock);
    `CHK(link.status_level, glue_status_data)
    status_value = r[15:12];
    status_to_controller = 1'b1;
    repeat (3) @(negedge clock);
    `CHK(link.status_level, status_value)
    hold_controller = 1'b1;
    `WAIT(link.controller_reset === 1'b1)
    repeat (2) @(negedge clock);
    `CHK({sram_chip_select_n, link.mux_addr_data_port}, 9'h1FF)
    hold_controller = 1'b0;
    `WAIT(link.controller_reset === 1'b0)
    run_op(MSG_READ, 16'h0103, 8'h00);
    test_done();
  end
endmodule // tb_top
